// *** include/rsm_pkg.sv ***
// Shared constants, types and register map of the reset and supply monitor control block.
package rsm_pkg;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_SUPPLY_CTRL = 8'h00;
   localparam logic [7:0] OFS_RESET_SRC = 8'h04;
   localparam logic [7:0] OFS_PWR_MODE = 8'h08;
   // Supply monitor control fields.
   localparam int B_DIG_EN = 7;
   localparam int B_DIG_STAT = 6;
   localparam int B_DIG_OK = 5;
   localparam int B_DIG_IE = 4;
   localparam int B_ANA_EN = 3;
   localparam int B_ANA_STAT = 2;
   localparam int B_ANA_OK = 1;
   localparam int B_ANA_IE = 0;
   // Reset source fields.
   localparam int B_POR_FLAG = 1;
   localparam int B_SW_RESET = 4;
   localparam int B_FLASH_ERR = 6;
   // Power unit mode fields.
   localparam int B_SLEEP = 0;
   localparam int B_MON_DIS = 5;
   // Values after a power-on or power-fail reset.
   localparam logic DIG_EN_RST = 1'b1;
   localparam logic MON_SEL_RST = 1'b1;
   localparam logic ANA_EN_RST = 1'b0;
   localparam logic IE_RST = 1'b0;
   localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
   localparam logic [15:0] PC_RST = 16'h0000;
   // Timing.
   localparam int CLK_HZ = 20_000_000;
   localparam int POR_DELAY_MS = 7;
   localparam int POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);
   localparam int OTHER_HOLD_CYC = 4;
   localparam int WDT_DIV = 12;
   // Supply comparator outputs, all high while the supply is above the threshold.
   typedef struct packed {
      logic por_ok;
      logic dig_rst_ok;
      logic dig_warn_ok;
      logic ana_rst_ok;
      logic ana_warn_ok;
   } supply_s;
   // Reset sequencer states.
   typedef enum logic [3:0] {
      ST_POR = 4'b0001,
      ST_MON = 4'b0010,
      ST_OTH = 4'b0100,
      ST_RUN = 4'b1000
   } state_e;
endpackage

// *** rtl/reset_supply_ctrl.sv ***
// Reset sequencer with power-on delay, supply monitors and an AHB-Lite register slave.
// What this block does
// R01 - Reset halts core, loads registers, disables interrupts
// R02 - Reset leaves RAM contents untouched
// R03 - Port latches all ones, open-drain, pull-ups on
// R04 - Power-on and monitor resets drive pin low
// R05 - Exit restarts fetch at zero, internal oscillator
// R06 - Exit enables watchdog at clock divided twelve
// R07 - Hold until supply good, then release delay
// R08 - Power-on flag set; other resets clear it
// R09 - Disabled power-on monitor turns resets into full
// R10 - Power-fail: digital monitor on, analog off
// R11 - Low selected supply holds reset until recovery
// R12 - Power-fail reads flag one, RAM invalid
// R13 - Only power resets change monitor enable/select
// R14 - Sleep disables monitors, wake restores software state
// R15 - Early-warning bit clears below warning threshold
// R16 - Flash write without digital monitor resets
// R17 - Monitor reset skips the power-on delay
// R18 - Firmware always writes the flag bit one
// R19 - Firmware enables monitor before selecting it
// R20 - Firmware enables analog monitor on converter supply
// R21 - Control bits: 7-4 digital; 3-0 analog
// R22 - Internal reset ORs all active sources; here it drops for one cycle when a monitor fault outlasts the power-on delay
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
module reset_supply_ctrl
   import rsm_pkg::*;
#(
   parameter int POR_CYC = POR_DELAY_CYC
) (
   // Clock, reset and clock enable.
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Analog comparators, asynchronous to hclk.
   input wire supply_s supply_in,
   // Same-clock events from the core side.
   input wire logic flash_wr_req,
   input wire logic wake_evt,
   // Open-drain reset pin.
   output logic rst_pin_o,
   output logic rst_pin_oe,
   // Controls toward the rest of the device.
   output logic core_reset,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic osc_internal,
   output logic port_force,
   output logic [7:0] port_latch,
   output logic port_open_drain,
   output logic weak_pullup_en,
   output logic wdt_enable,
   output logic wdt_tick,
   output logic ram_invalid,
   output logic warn_irq
);
   localparam int CW = $clog2(POR_CYC + 1);
   localparam int WW = $clog2(WDT_DIV);

   // The shared counter must also reach the short hold, so it is refused when narrower.
   if (POR_CYC < OTHER_HOLD_CYC) begin : g_bad_por
      $error("POR_CYC must not be below the short reset hold");
   end

   // Three-stage synchroniser; the value changes once stages two and three agree.
   supply_s s1_q, s2_q, s3_q, sup_q;
   // Sequencer state and shared hold counter.
   state_e state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   // Stored software state.
   logic dig_en_q, ana_en_q, mon_sel_q, dig_ie_q, ana_ie_q;
   logic mon_dis_q, sleep_q, por_flag_q, ferr_q, ram_bad_q;
   logic [WW-1:0] wdt_q;
   logic irq_q;
   // Bus data phase capture.
   logic wr_ph_q;
   logic [7:0] ad_q;
   logic [31:0] rdata_q;

   // Synchroniser chain; only the filtered copy feeds any logic.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sup_q <= '0;
      end else if (ce) begin
         s1_q <= supply_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            sup_q <= s3_q;
         end
      end
   end

   // Bus decode; any NONSEQ or SEQ transfer is taken, and the transfer size is not checked.
   wire addr_ph = hsel && hready && htrans[1];
   wire wr_now = wr_ph_q;
   wire wr_ctrl = wr_now && (ad_q == OFS_SUPPLY_CTRL);
   wire wr_rsrc = wr_now && (ad_q == OFS_RESET_SRC);
   wire wr_pmode = wr_now && (ad_q == OFS_PWR_MODE);

   // Monitors are forced off in sleep; the stored bits survive for the wake. [R14]
   wire dig_act = dig_en_q && !sleep_q;
   wire ana_act = ana_en_q && !sleep_q;
   // The power-on comparator is honoured only while not disabled, even in sleep. [R09]
   wire por_fail = !mon_dis_q && !sup_q.por_ok;
   // A selected, active monitor below its reset threshold. [R11]
   wire mon_fail = mon_sel_q && ((dig_act && !sup_q.dig_rst_ok) || (ana_act && !sup_q.ana_rst_ok));
   // Flash writes without the digital monitor are an error. [R16]
   wire flash_err = flash_wr_req && !dig_en_q;
   wire sw_rst = wr_rsrc && hwdata[B_SW_RESET];
   wire oth_evt = (flash_err || sw_rst) && (state_q == ST_RUN);
   wire cnt_por_done = (cnt_q == CW'(POR_CYC - 1));
   wire cnt_oth_done = (cnt_q == CW'(OTHER_HOLD_CYC - 1));
   wire leave = (state_q != ST_RUN) && (state_d == ST_RUN);
   wire leave_pwr = leave && (state_q != ST_OTH);

   // Next state: the internal reset is held while any source stays active, but drops for one cycle when a monitor fault outlasts the power-on delay. [R22]
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (por_fail) begin
         // Supply below the power-on threshold restarts the whole delay. [R07]
         state_d = ST_POR;
         cnt_d = '0;
      end else if (mon_fail && state_q != ST_POR) begin
         // With the power-on monitor off, a monitor reset is a full one too. [R09]
         state_d = mon_dis_q ? ST_POR : ST_MON;
         cnt_d = '0;
      end else begin
         unique case (state_q)
            ST_POR: begin
               // Release after the full delay counted from a good supply. [R07]
               cnt_d = cnt_q + CW'(1);
               if (cnt_por_done) begin
                  state_d = ST_RUN;
               end
            end
            ST_MON: begin
               // Recovery releases at once, with no power-on delay. [R17]
               state_d = ST_RUN;
            end
            ST_OTH: begin
               cnt_d = cnt_q + CW'(1);
               if (cnt_oth_done) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (oth_evt) begin
                  // With the power-on monitor off, any reset becomes a full one. [R09]
                  state_d = mon_dis_q ? ST_POR : ST_OTH;
                  cnt_d = '0;
               end
            end
         endcase
      end
   end

   // Sequencer state register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_POR;
         cnt_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Monitor enables and selection; only power resets reload them. [R13]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dig_en_q <= DIG_EN_RST;
         ana_en_q <= ANA_EN_RST;
         mon_sel_q <= MON_SEL_RST;
         mon_dis_q <= 1'b0;
      end else if (ce) begin
         if (state_d == ST_POR || state_d == ST_MON) begin
            // Power resets restore digital on and selected, analog off. [R10] [R12]
            dig_en_q <= DIG_EN_RST;
            ana_en_q <= ANA_EN_RST;
            mon_sel_q <= MON_SEL_RST;
         end else if (wr_ctrl) begin
            // Enable bits sit at their fixed positions. [R21]
            dig_en_q <= hwdata[B_DIG_EN];
            ana_en_q <= hwdata[B_ANA_EN];
         end else if (wr_rsrc) begin
            // Writing the flag bit as one keeps the monitor selected. [R18]
            mon_sel_q <= hwdata[B_POR_FLAG];
         end
         if (state_d == ST_POR) begin
            // A full power-on re-enables the power-on monitor. [R09]
            mon_dis_q <= 1'b0;
         end else if (wr_pmode) begin
            mon_dis_q <= hwdata[B_MON_DIS];
         end
      end
   end

   // Interrupt enables, sleep request and cause flags.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dig_ie_q <= IE_RST;
         ana_ie_q <= IE_RST;
         sleep_q <= 1'b0;
         por_flag_q <= 1'b1;
         ferr_q <= 1'b0;
         ram_bad_q <= 1'b1;
      end else if (ce) begin
         if (core_reset) begin
            // Every reset returns enables to their reset values. [R01]
            dig_ie_q <= IE_RST;
            ana_ie_q <= IE_RST;
            sleep_q <= 1'b0;
         end else begin
            if (wr_ctrl) begin
               dig_ie_q <= hwdata[B_DIG_IE];
               ana_ie_q <= hwdata[B_ANA_IE];
            end
            // Wake wins over a sleep request in the same cycle.
            if (wake_evt) begin
               sleep_q <= 1'b0;
            end else if (wr_pmode) begin
               sleep_q <= hwdata[B_SLEEP];
            end
         end
         if (leave) begin
            // Power resets set the flag; any other reset clears it. [R08] [R12]
            por_flag_q <= leave_pwr;
            ferr_q <= (state_q == ST_OTH) && ferr_q;
            ram_bad_q <= leave_pwr;
         end
         if (oth_evt && flash_err) begin
            ferr_q <= 1'b1;
         end
      end
   end

   // Watchdog prescaler runs from the system clock whenever out of reset. [R06]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_q <= '0;
      end else if (ce) begin
         if (core_reset || wdt_q == WW'(WDT_DIV - 1)) begin
            wdt_q <= '0;
         end else begin
            wdt_q <= wdt_q + WW'(1);
         end
      end
   end

   // Early-warning bits clear below the warning threshold. [R15]
   wire dig_ok = dig_act && sup_q.dig_warn_ok;
   wire ana_ok = ana_act && sup_q.ana_warn_ok;
   wire [7:0] ctrl_rd = {dig_en_q, dig_act && sup_q.dig_rst_ok, dig_ok, dig_ie_q,
                         ana_en_q, ana_act && sup_q.ana_rst_ok, ana_ok, ana_ie_q};
   wire [7:0] rsrc_rd = {1'b0, ferr_q, 4'h0, por_flag_q, 1'b0};
   wire [7:0] pmode_rd = {2'h0, mon_dis_q, 4'h0, sleep_q};
   wire [7:0] rd_sel = (haddr == OFS_SUPPLY_CTRL) ? ctrl_rd :
                       (haddr == OFS_RESET_SRC) ? rsrc_rd :
                       (haddr == OFS_PWR_MODE) ? pmode_rd : 8'h00;

   // Bus phase capture; reads are latched at the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q <= 1'b0;
         ad_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         wr_ph_q <= addr_ph && hwrite;
         if (addr_ph) begin
            ad_q <= haddr;
            rdata_q <= {24'h00_0000, rd_sel};
         end
      end
   end

   // Early-warning interrupt, enabled per monitor. [R15]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= !core_reset && ((dig_ie_q && dig_act && !sup_q.dig_warn_ok) ||
                                  (ana_ie_q && ana_act && !sup_q.ana_warn_ok));
      end
   end

   // The slave answers with no wait states and always OKAY.
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Reset pin pulled low only for power-on and monitor resets. [R04]
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe = (state_q == ST_POR) || (state_q == ST_MON);
   // Core, timers and interrupts held while not running. [R01] [R22]
   assign core_reset = (state_q != ST_RUN);
   // RAM has no clear strobe here, so its bytes outlive any reset. [R02]
   assign ram_invalid = ram_bad_q;
   // Fetch restarts at zero on the internal oscillator. [R05]
   assign pc_load = core_reset;
   assign pc_value = PC_RST;
   assign osc_internal = core_reset;
   // Port latches forced to ones in open-drain mode, pull-ups kept on. [R03]
   assign port_force = core_reset;
   assign port_latch = PORT_LATCH_RST;
   assign port_open_drain = core_reset;
   assign weak_pullup_en = 1'b1;
   // Watchdog enabled on exit from any reset. [R06]
   assign wdt_enable = !core_reset;
   assign wdt_tick = !core_reset && (wdt_q == WW'(WDT_DIV - 1));
   assign warn_irq = irq_q;
endmodule

// *** dv/reset_supply_ctrl_monitor.sv ***
// Concurrent checks on the reset controller's outputs, bound to its top.
module reset_supply_ctrl_monitor (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Reset pin and core controls.
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic core_reset,
   input wire logic pc_load,
   input wire logic [15:0] pc_value,
   input wire logic osc_internal,
   input wire logic port_force,
   input wire logic [7:0] port_latch,
   input wire logic port_open_drain,
   input wire logic weak_pullup_en,
   input wire logic wdt_enable,
   input wire logic wdt_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so one default clock and disable.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_pin_in_reset: assert property (rst_pin_oe |-> core_reset && !rst_pin_o)
      else $error("reset pin driven outside reset");
   a_wdt_on_exit: assert property (wdt_enable == !core_reset)
      else $error("watchdog enable does not follow reset exit");
   a_tick_period: assert property (wdt_tick ##1 (!core_reset [*6]) ##1 (!core_reset [*5])
      |-> ##1 (wdt_tick || core_reset))
      else $error("watchdog tick not twelve cycles apart");
   a_tick_gap: assert property (wdt_tick |-> !core_reset ##1 (!wdt_tick [*8]))
      else $error("watchdog tick too early or in reset");
   a_ports_forced: assert property (core_reset |->
      port_force && port_open_drain && port_latch == 8'hFF)
      else $error("port pins not forced during reset");
   a_pullup_kept: assert property (weak_pullup_en)
      else $error("weak pull-ups off");
   a_fetch_zero: assert property (core_reset |->
      pc_load && osc_internal && pc_value == 16'h0000)
      else $error("fetch address or clock not set in reset");
   a_reset_hold: assert property ($rose(core_reset) |-> core_reset [*4])
      else $error("internal reset shorter than four cycles");
endmodule

bind reset_supply_ctrl reset_supply_ctrl_monitor mon (
   .hclk, .hresetn, .rst_pin_o, .rst_pin_oe, .core_reset, .pc_load, .pc_value,
   .osc_internal, .port_force, .port_latch, .port_open_drain, .weak_pullup_en,
   .wdt_enable, .wdt_tick);

// *** dv/supply_model.sv ***
// Supply comparators and the pulled-up reset pin outside the controller.
module supply_model
   import rsm_pkg::*;
(
   // Requested levels, high meaning above the threshold.
   input wire logic [4:0] level,
   // Open-drain pin drive from the controller.
   input wire logic pin_o,
   input wire logic pin_oe,
   // Comparator view and resolved pin level.
   output supply_s supply,
   output logic rst_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Comparators follow the requested levels directly.
   assign supply = level;
   // The external pull-up wins whenever nobody drives the pin.
   assign rst_pin = pin_oe ? pin_o : 1'h1;
endmodule

// *** dv/tb_top.sv ***
// Directed bench for the reset and supply monitor controller.
module tb_top
   import rsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POR_C = 20;
   // Bus master, event and supply stimulus.
   logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, flash_wr_req = 0, wake_evt = 0;
   logic [1:0] htrans = 0;
   logic [7:0] haddr = 0, port_latch;
   logic [31:0] hwdata = 0, rd, hrdata;
   logic [4:0] lvl = 5'h1F;
   // Design outputs.
   logic hreadyout, hresp, rst_pin_o, rst_pin_oe, core_reset, pc_load, osc_internal;
   logic port_force, port_open_drain, weak_pullup_en, wdt_enable, wdt_tick;
   logic ram_invalid, warn_irq, rst_pin;
   logic [15:0] pc_value;
   supply_s sup;
   int failures = 0, n_compared = 0, n;
   always #25 hclk = ~hclk;
   // The transfer size is held at its only used value.
   reset_supply_ctrl #(.POR_CYC(POR_C)) dut (
      .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .supply_in(sup),
      .flash_wr_req, .wake_evt, .rst_pin_o, .rst_pin_oe, .core_reset, .pc_load,
      .pc_value, .osc_internal, .port_force, .port_latch, .port_open_drain,
      .weak_pullup_en, .wdt_enable, .wdt_tick, .ram_invalid, .warn_irq);
   supply_model sm (.level(lvl), .pin_o(rst_pin_o), .pin_oe(rst_pin_oe),
      .supply(sup), .rst_pin);
   // One single transfer; a read leaves its data in rd.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1)
         @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1)
         @(posedge hclk);
      rd = hrdata;
   endtask
   // Compares one value and counts it.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(what, exp, rd);
      chk("read resp", 32'h0, {31'h0, hresp});
   endtask
   // Waits whole cycles, then stops at the falling edge where outputs are settled.
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
      @(negedge hclk);
   endtask
   // Counts cycles until the internal reset ends; the bound turns a hang into a mismatch.
   task automatic wait_rel();
      n = 0;
      while (core_reset !== 1'h0 && n < 400) begin
         @(negedge hclk);
         n++;
      end
      chk("release", 32'h0, {31'h0, core_reset});
   endtask
   task automatic setl(input int b, input logic v);
      @(posedge hclk);
      lvl[b] <= v;
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Watchdog: the tests need well under a thousand cycles, this allows four thousand.
   initial begin
      #200000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      wait_rel();
      chk("por delay", 1, n >= POR_C && n <= POR_C + 8);
      rdchk("por flag", OFS_RESET_SRC, 32'h2);
      rdchk("ctrl after por", OFS_SUPPLY_CTRL, 32'hE0);
      chk("ram after por", 1, ram_invalid);
      $display("test power_on done");
      setl(2, 1'h0);
      cyc(6);
      rdchk("early warn", OFS_SUPPLY_CTRL, 32'hC0);
      bus(1'h1, OFS_SUPPLY_CTRL, 32'h90);
      cyc(3);
      chk("warn irq", 1, warn_irq);
      setl(2, 1'h1);
      bus(1'h1, OFS_SUPPLY_CTRL, 32'h88);
      cyc(6);
      rdchk("analog on", OFS_SUPPLY_CTRL, 32'hEE);
      $display("test warning done");
      setl(3, 1'h0);
      cyc(8);
      chk("mon hold", 1, core_reset);
      chk("mon pin", 0, rst_pin);
      setl(3, 1'h1);
      wait_rel();
      chk("mon delay", 1, n < POR_C / 2);
      rdchk("mon flag", OFS_RESET_SRC, 32'h2);
      chk("ram after mon", 1, ram_invalid);
      rdchk("ctrl after mon", OFS_SUPPLY_CTRL, 32'hE0);
      $display("test monitor done");
      bus(1'h1, OFS_SUPPLY_CTRL, 32'h0);
      bus(1'h1, OFS_RESET_SRC, 32'h10);
      cyc(1);
      chk("sw hold", 1, core_reset);
      chk("sw pin", 1, rst_pin);
      wait_rel();
      rdchk("sw flag", OFS_RESET_SRC, 32'h0);
      rdchk("kept off", OFS_SUPPLY_CTRL, 32'h0);
      chk("ram kept", 0, ram_invalid);
      $display("test software done");
      @(posedge hclk);
      flash_wr_req <= 1'h1;
      @(posedge hclk);
      flash_wr_req <= 1'h0;
      cyc(1);
      wait_rel();
      rdchk("flash error", OFS_RESET_SRC, 32'h40);
      bus(1'h1, OFS_SUPPLY_CTRL, 32'h80);
      bus(1'h1, OFS_RESET_SRC, 32'h2);
      $display("test flash done");
      bus(1'h1, OFS_PWR_MODE, 32'h1);
      setl(3, 1'h0);
      cyc(8);
      chk("sleep no reset", 0, core_reset);
      setl(3, 1'h1);
      // Let the supply settle first, so only the wake can restore the selection.
      cyc(6);
      @(posedge hclk);
      wake_evt <= 1'h1;
      @(posedge hclk);
      wake_evt <= 1'h0;
      cyc(6);
      rdchk("woken ctrl", OFS_SUPPLY_CTRL, 32'hE0);
      setl(3, 1'h0);
      cyc(8);
      chk("select restored", 1, core_reset);
      setl(3, 1'h1);
      wait_rel();
      $display("test sleep done");
      bus(1'h1, OFS_PWR_MODE, 32'h20);
      bus(1'h1, OFS_RESET_SRC, 32'h12);
      cyc(2);
      chk("full por pin", 0, rst_pin);
      wait_rel();
      chk("full por delay", 1, n >= POR_C - 3);
      rdchk("full por flag", OFS_RESET_SRC, 32'h2);
      rdchk("monitor back on", OFS_PWR_MODE, 32'h0);
      $display("test monitor_disable done");
      // A write made while the clock enable is low must leave no trace.
      @(posedge hclk);
      ce <= 1'h0;
      bus(1'h1, OFS_SUPPLY_CTRL, 32'h0);
      ce <= 1'h1;
      rdchk("frozen write", OFS_SUPPLY_CTRL, 32'hE0);
      $display("test clock_enable done");
      give_verdict();
   end
endmodule
